/* src/brd_board.sv */
// bus interface, ram array and control of the banked ram board
//
// Contract
// - 8k bytes as two separately placed 4k sections
// - each 1k byte range uses one chip pair
// - bank switch limits answers to one bank
// - bank line compared with bank switches
// - per section base switches matched to upper address
// - one of eight chip selects from decode
// - chip-selected indication to write and transceiver logic
// - write enable only when section unprotected
// - protected section keeps transceivers off on writes
// - transceiver enable and direction from valid cycle
// - transceivers enabled only on bank and base match
// - 8-bit data through inverting transceivers, active low
// - 16 inverted address bits to all decoders
// - clock, read/write taken uninverted; drive bus active low
`timescale 1ns/100ps
`include "brd_cfg.svh"

module brd_board #(
    parameter int ADDR_W = `BRD_ADDR_W,
    parameter int DATA_W = `BRD_DATA_W,
    parameter int BYTES = `BRD_BYTES
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic bank_addr_n,
    input wire logic [ADDR_W-1:0] bus_addr_n,
    input wire logic bus_rd_wr,
    input wire logic bus_phi2,
    input wire logic [DATA_W-1:0] bus_data_n_in,
    output logic [DATA_W-1:0] bus_data_n_out,
    output logic bus_data_oe,
    output logic bus_active_n,
    input wire brd_pkg::brd_switch_t sw,
    output logic [7:0] chip_sel_q,
    output logic ram_we_q,
    output logic xcvr_en_q,
    output logic xcvr_to_bus_q
);
    import brd_pkg::*;

    // synchroniser stages; stage 1 feeds only stage 2
    logic bank_n_s1_q;
    logic bank_n_s2_q;
    logic [ADDR_W-1:0] addr_n_s1_q;
    logic [ADDR_W-1:0] addr_n_s2_q;
    logic rd_wr_s1_q;
    logic rd_wr_s2_q;
    logic phi2_s1_q;
    logic phi2_s2_q;
    logic [DATA_W-1:0] data_n_s1_q;
    logic [DATA_W-1:0] data_n_s2_q;
    brd_switch_t sw_s1_q;
    brd_switch_t sw_s2_q;

    // buffered copies seen by the board; address, bank and data inverted
    logic [ADDR_W-1:0] addr;
    logic bank_addr;
    logic rd;
    logic phi2;
    logic [DATA_W-1:0] wr_data;

    brd_dec_t dec;
    logic [$clog2(BYTES)-1:0] ram_idx;
    logic prot;
    logic valid;
    logic cs_to_wr;
    logic cs_to_xcvr;
    logic rd_cycle;
    logic wr_cycle;
    logic ram_we_d;
    logic xcvr_en_d;
    logic drive_d;

    logic [DATA_W-1:0] ram_q [BYTES];

    // address and bank lines; decode only ever sees stage 2
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bank_n_s1_q <= `BRD_RST_N_LEVEL;
            bank_n_s2_q <= `BRD_RST_N_LEVEL;
            addr_n_s1_q <= '1;
            addr_n_s2_q <= '1;
        end else begin
            bank_n_s1_q <= bank_addr_n;
            bank_n_s2_q <= bank_n_s1_q;
            addr_n_s1_q <= bus_addr_n;
            addr_n_s2_q <= addr_n_s1_q;
        end
    end

    // control lines share the address depth so phase 2 never leads the address
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rd_wr_s1_q <= `BRD_RST_N_LEVEL;
            rd_wr_s2_q <= `BRD_RST_N_LEVEL;
            phi2_s1_q <= `BRD_RST_LEVEL;
            phi2_s2_q <= `BRD_RST_LEVEL;
        end else begin
            rd_wr_s1_q <= bus_rd_wr;
            rd_wr_s2_q <= rd_wr_s1_q;
            phi2_s1_q <= bus_phi2;
            phi2_s2_q <= phi2_s1_q;
        end
    end

    // write data; same depth as phase 2, so the master need only hold it to the end of phase 2
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            data_n_s1_q <= '1;
            data_n_s2_q <= '1;
        end else begin
            data_n_s1_q <= bus_data_n_in;
            data_n_s2_q <= data_n_s1_q;
        end
    end

    // switches are static but still come from off-chip
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sw_s1_q <= '0;
            sw_s2_q <= '0;
        end else begin
            sw_s1_q <= sw;
            sw_s2_q <= sw_s1_q;
        end
    end

    assign addr = ~addr_n_s2_q;
    assign bank_addr = ~bank_n_s2_q;
    assign rd = rd_wr_s2_q;
    assign phi2 = phi2_s2_q;
    assign wr_data = ~data_n_s2_q;

    brd_cs_decoder u_dec (
        .sw(sw_s2_q),
        .addr(addr),
        .bank_addr(bank_addr),
        .dec(dec)
    );

    // section picks the array half; a11 and a10 stay inside the index
    assign ram_idx = {dec.section, addr[`BRD_SEC_ADDR_W-1:0]};
    // protection follows the section that actually won the decode
    assign prot = sw_s2_q.wr_prot[dec.section];

    // the chip-selected indication fans out to write and transceiver control
    assign cs_to_wr = dec.any_cs;
    assign cs_to_xcvr = dec.any_cs;

    // a cycle is ours only in phase 2 with a decoded select
    assign valid = phi2 && cs_to_xcvr;
    assign rd_cycle = valid && rd;
    assign wr_cycle = phi2 && cs_to_wr && !rd;
    assign ram_we_d = wr_cycle && !prot;
    // protected writes never open the transceivers
    assign xcvr_en_d = valid && (rd || !prot);
    assign drive_d = rd_cycle;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            chip_sel_q <= `BRD_RST_CS;
        end else begin
            chip_sel_q <= phi2 ? dec.chip_sel : `BRD_RST_CS;
        end
    end

    // write control
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ram_we_q <= `BRD_RST_LEVEL;
        end else begin
            ram_we_q <= ram_we_d;
        end
    end

    // transceiver control; direction only points at the bus while enabled
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            xcvr_en_q <= `BRD_RST_LEVEL;
            xcvr_to_bus_q <= `BRD_RST_LEVEL;
        end else begin
            xcvr_en_q <= xcvr_en_d;
            xcvr_to_bus_q <= xcvr_en_d && rd;
        end
    end

    // the array holds no reset so it maps onto plain ram
    // the synchronised data is re-stored each phase 2 cycle; last sample wins
    always_ff @(posedge clock) begin
        if (ram_we_d) begin
            ram_q[ram_idx] <= wr_data;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bus_data_oe <= `BRD_RST_LEVEL;
        end else begin
            bus_data_oe <= drive_d;
        end
    end

    // idle data sits at the released level so a stray enable shows no byte
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bus_data_n_out <= `BRD_RST_BYTE_N;
        end else begin
            bus_data_n_out <= drive_d ? ~ram_q[ram_idx] : `BRD_RST_BYTE_N;
        end
    end

    // any decoded access, protected writes included, shows as active
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bus_active_n <= `BRD_RST_N_LEVEL;
        end else begin
            bus_active_n <= !valid;
        end
    end

endmodule // brd_board

/* src/brd_cfg.svh */
// constants for the banked ram board decoder
`ifndef BRD_CFG_SVH
`define BRD_CFG_SVH

`define BRD_ADDR_W 16
`define BRD_DATA_W 8
`define BRD_SECTIONS 2
`define BRD_CHIP_SELS 8
`define BRD_BYTES 8192
`define BRD_SEC_ADDR_W 12
`define BRD_BASE_MSB 15
`define BRD_BASE_LSB 12
`define BRD_PAGE_MSB 11
`define BRD_PAGE_LSB 10
`define BRD_SYNC_STAGES 2
`define BRD_RST_N_LEVEL 1'b1
`define BRD_RST_LEVEL 1'b0
`define BRD_RST_BYTE_N 8'hff
`define BRD_RST_CS 8'h00
`define BRD_FULL_SIZE 2'h3

`endif

/* src/brd_pkg.sv */
// types shared by the banked ram board decoder
package brd_pkg;

    // static board switches and jumpers
    typedef struct packed {
        logic bank_sel;
        logic bank_chk_en;
        logic [3:0] base1;
        logic [3:0] base0;
        logic [1:0] wr_prot;
        logic [1:0] size1;
        logic [1:0] size0;
    } brd_switch_t;

    // decode result for one bus cycle
    typedef struct packed {
        logic [7:0] chip_sel;
        logic any_cs;
        logic section;
        logic bank_ok;
        logic [1:0] sec_hit;
    } brd_dec_t;

endpackage

/* src/brd_cs_decoder.sv */
// bank compare, base compare and chip select decode
`timescale 1ns/100ps
`include "brd_cfg.svh"

module brd_cs_decoder (
    input wire brd_pkg::brd_switch_t sw,
    input wire logic [15:0] addr,
    input wire logic bank_addr,
    output brd_pkg::brd_dec_t dec
);
    import brd_pkg::*;

    logic [1:0] base_hit;
    logic [1:0] page_ok;
    logic [1:0] sec_hit;
    logic bank_ok;
    logic section;
    logic [1:0] page;

    // with the check switch off the board answers in both banks
    assign bank_ok = !sw.bank_chk_en || (bank_addr == sw.bank_sel);
    assign page = addr[`BRD_PAGE_MSB:`BRD_PAGE_LSB];

    genvar s;
    generate
        for (s = 0; s < `BRD_SECTIONS; s++) begin : g_sec
            logic [3:0] base;
            logic [1:0] size;
            assign base = (s == 0) ? sw.base0 : sw.base1;
            assign size = (s == 0) ? sw.size0 : sw.size1;
            assign base_hit[s] = addr[`BRD_BASE_MSB:`BRD_BASE_LSB] == base;
            // unpopulated upper pages stay silent
            assign page_ok[s] = page <= size;
            assign sec_hit[s] = bank_ok && base_hit[s] && page_ok[s];
        end
    endgenerate

    // section 0 wins when both bases are set alike, keeping one select
    assign section = !sec_hit[0];

    genvar c;
    generate
        for (c = 0; c < `BRD_CHIP_SELS; c++) begin : g_cs
            // each select drives one 1k pair of nibble-wide chips
            assign dec.chip_sel[c] = sec_hit[c / 4] && (section == 1'(c / 4))
                && (page == 2'(c % 4));
        end
    endgenerate

    assign dec.any_cs = |sec_hit;
    assign dec.section = section;
    assign dec.bank_ok = bank_ok;
    assign dec.sec_hit = sec_hit;

endmodule // brd_cs_decoder

/* sim/brd_bus_master.sv */
// bus master model that runs phase 2 read and write cycles
`timescale 1ns/100ps
module brd_bus_master (
    input wire logic clock,
    input wire logic [7:0] wire_n,
    output logic bank_addr_n = 1'b1,
    output logic [15:0] bus_addr_n = 16'hffff,
    output logic bus_rd_wr = 1'b1,
    output logic bus_phi2 = 1'b0,
    output logic [7:0] m_n = 8'hff,
    output logic m_oe = 1'b0
);
    task cycle(input logic bk, input logic [15:0] a, input logic rd, input logic [7:0] wd,
        output logic [7:0] rdat);
        @(posedge clock);
        bank_addr_n <= !bk;
        bus_addr_n <= ~a;
        bus_rd_wr <= rd;
        m_n <= ~wd;
        m_oe <= !rd;
        // setup margin covers the board's input synchronisers
        repeat (3) @(posedge clock);
        bus_phi2 <= 1'b1;
        repeat (8) @(posedge clock);
        rdat = ~wire_n;
        bus_phi2 <= 1'b0;
        repeat (4) @(posedge clock);
        // released lines fall back to their pull-ups
        bus_addr_n <= 16'hffff;
        m_oe <= 1'b0;
        m_n <= 8'hff;
        bank_addr_n <= 1'b1;
        bus_rd_wr <= 1'b1;
        repeat (4) @(posedge clock);
    endtask
endmodule // brd_bus_master

/* sim/brd_board_checker.sv */
// port assertions for the banked ram board
`timescale 1ns/100ps
module brd_board_checker (
    input wire logic clock,
    input wire logic resetn,
    input wire logic bank_addr_n,
    input wire logic [15:0] bus_addr_n,
    input wire logic bus_rd_wr,
    input wire logic bus_phi2,
    input wire logic [7:0] bus_data_n_out,
    input wire logic bus_data_oe,
    input wire logic bus_active_n,
    input wire brd_pkg::brd_switch_t sw,
    input wire logic [7:0] chip_sel_q,
    input wire logic ram_we_q,
    input wire logic xcvr_en_q,
    input wire logic xcvr_to_bus_q
);
    import brd_pkg::*;
    logic [15:0] a;
    logic bok, h0, h1, v, pr;
    logic [2:0] ix;
    logic [5:0] p1_q, p2_q, p3_q;
    assign a = ~bus_addr_n;
    assign bok = !sw.bank_chk_en || (!bank_addr_n == sw.bank_sel);
    assign h0 = bok && a[15:12] == sw.base0 && a[11:10] <= sw.size0;
    assign h1 = bok && a[15:12] == sw.base1 && a[11:10] <= sw.size1;
    assign v = bus_phi2 && (h0 || h1);
    // section 0 wins when both match
    assign ix = {!h0, a[11:10]};
    assign pr = sw.wr_prot[ix[2]] && !bus_rd_wr;
    // three-edge pipe mirrors synchroniser plus output register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            p1_q <= 6'h00;
            p2_q <= 6'h00;
            p3_q <= 6'h00;
        end else begin
            p1_q <= {v, bus_rd_wr, pr, ix};
            p2_q <= p1_q;
            p3_q <= p2_q;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    idle_out_a: assert property (!p3_q[5] |-> bus_active_n && !bus_data_oe && !ram_we_q
        && !xcvr_en_q && chip_sel_q == 8'h00) else $error("idle board drove outputs");
    resp_sel_a: assert property (p3_q[5] |-> !bus_active_n
        && chip_sel_q == (8'h01 << p3_q[2:0])) else $error("wrong chip select");
    read_oe_a: assert property (bus_data_oe == (p3_q[5] && p3_q[4]))
        else $error("data drive mismatch");
    write_en_a: assert property (ram_we_q == (p3_q[5] && !p3_q[4] && !p3_q[3]))
        else $error("write enable mismatch");
    xcvr_en_a: assert property (xcvr_en_q == (p3_q[5] && !p3_q[3]))
        else $error("transceiver enable mismatch");
    xcvr_dir_a: assert property (xcvr_en_q |-> xcvr_to_bus_q == p3_q[4])
        else $error("transceiver direction wrong");
    float_data_a: assert property (!bus_data_oe |-> bus_data_n_out == 8'hff)
        else $error("data not idle");
    read_hold_a: assert property (bus_data_oe && $past(bus_data_oe) |-> $stable(bus_data_n_out))
        else $error("read data moved");
    cover property (bus_data_oe);
    cover property (ram_we_q);
    cover property (!bus_active_n && !xcvr_en_q);
endmodule // brd_board_checker

/* sim/tb.sv */
// testbench for the banked ram board
`timescale 1ns/100ps
module tb;
    import brd_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    brd_switch_t sw = '0;
    logic [15:0] bus_addr_n;
    logic [7:0] bus_data_n_out, chip_sel_q, m_n, wire_n, r;
    logic bank_addr_n, bus_rd_wr, bus_phi2, bus_data_oe, bus_active_n, ram_we_q, xcvr_en_q;
    logic xcvr_to_bus_q, m_oe;
    int error_cnt = 0;
    int compares = 0;
    // pulled-up active-low data wire
    assign wire_n = bus_data_oe ? bus_data_n_out : (m_oe ? m_n : 8'hff);
    brd_board dut (.clock(clock), .resetn(resetn), .bank_addr_n(bank_addr_n),
        .bus_addr_n(bus_addr_n), .bus_rd_wr(bus_rd_wr), .bus_phi2(bus_phi2),
        .bus_data_n_in(wire_n), .bus_data_n_out(bus_data_n_out), .bus_data_oe(bus_data_oe),
        .bus_active_n(bus_active_n), .sw(sw), .chip_sel_q(chip_sel_q), .ram_we_q(ram_we_q),
        .xcvr_en_q(xcvr_en_q), .xcvr_to_bus_q(xcvr_to_bus_q));
    brd_bus_master m (.clock(clock), .wire_n(wire_n), .bank_addr_n(bank_addr_n),
        .bus_addr_n(bus_addr_n), .bus_rd_wr(bus_rd_wr), .bus_phi2(bus_phi2), .m_n(m_n),
        .m_oe(m_oe));
    always #5 clock = ~clock;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task rd(input logic bk, input logic [15:0] a, input logic [7:0] exp);
        m.cycle(bk, a, 1'b1, 8'h00, r);
        chk(r, exp);
    endtask
    task wr(input logic bk, input logic [15:0] a, input logic [7:0] d);
        m.cycle(bk, a, 1'b0, d, r);
    endtask
    // one address per chip pair: bases 2 and a
    function automatic logic [15:0] ad(input logic [2:0] i);
        return {i[2] ? 4'ha : 4'h2, i[1:0], 7'h78, i};
    endfunction
    task t_map;
        for (int i = 0; i < 8; i++) begin
            wr(1'b1, ad(3'(i)), 8'h5a ^ 8'(i));
        end
        for (int i = 0; i < 8; i++) begin
            rd(1'b1, ad(3'(i)), 8'h5a ^ 8'(i));
        end
    endtask
    task t_refuse;
        wr(1'b0, ad(3'd3), 8'hff);
        rd(1'b1, ad(3'd3), 8'h59);
        rd(1'b0, ad(3'd3), 8'h00);
        rd(1'b1, 16'h3000, 8'h00);
        sw <= 16'he887;
        rd(1'b1, ad(3'd6), 8'h00);
        rd(1'b1, ad(3'd5), 8'h5f);
        sw <= 16'ha88f;
        rd(1'b0, ad(3'd1), 8'h5b);
    endtask
    task t_prot;
        sw <= 16'he89f;
        wr(1'b1, ad(3'd0), 8'hc3);
        rd(1'b1, ad(3'd0), 8'h5a);
        wr(1'b1, ad(3'd4), 8'h3c);
        rd(1'b1, ad(3'd4), 8'h3c);
    endtask
    // bank 0 checked, section 0 two pages deep, section 1 protected, then a reset
    task t_bank0;
        sw <= 16'h68ad;
        rd(1'b0, ad(3'd1), 8'h5b);
        rd(1'b1, ad(3'd1), 8'h00);
        rd(1'b0, ad(3'd2), 8'h00);
        wr(1'b0, ad(3'd5), 8'h77);
        rd(1'b0, ad(3'd5), 8'h5f);
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        chk({bus_data_oe, bus_active_n, ram_we_q, xcvr_en_q, chip_sel_q[3:0]}, 8'h40);
        resetn <= 1'b1;
        rd(1'b0, ad(3'd4), 8'h3c);
    endtask
    task stop_test;
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock);
        chk({bus_data_oe, bus_active_n, ram_we_q, xcvr_en_q, chip_sel_q[3:0]}, 8'h40);
        resetn <= 1'b1;
        // bank 1 checked, bases 2 and a, full size, unprotected
        sw <= 16'he88f;
        t_map;
        t_refuse;
        t_prot;
        t_bank0;
        stop_test;
    end
    initial begin
        #100000;
        error_cnt++;
        stop_test;
    end
endmodule // tb
bind brd_board brd_board_checker u_chk (.clock(clock), .resetn(resetn),
    .bank_addr_n(bank_addr_n), .bus_addr_n(bus_addr_n), .bus_rd_wr(bus_rd_wr),
    .bus_phi2(bus_phi2), .bus_data_n_out(bus_data_n_out), .bus_data_oe(bus_data_oe),
    .bus_active_n(bus_active_n), .sw(sw), .chip_sel_q(chip_sel_q), .ram_we_q(ram_we_q),
    .xcvr_en_q(xcvr_en_q), .xcvr_to_bus_q(xcvr_to_bus_q));
